//--- rtl/osca_top.sv
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`include "osca_map.svh"
module osca_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic out1_i,
  input wire logic out2_i,
  input wire osca_pkg::osca_addr_t addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic aux1_o,
  output logic aux2_o,
  output logic disp_alarm_o,
  output logic irq_o
);
  import osca_pkg::*;
  osca_cnt_if c1 ();
  osca_cnt_if c2 ();
  logic [1:0] ctrl_ff;
  osca_count_t thr1_ff;
  osca_count_t thr2_ff;
  logic [3:0] route_ff;
  logic [1:0] sts_ff;
  logic [1:0] irq_en_ff;
  logic [1:0] alarm_d_ff;
  logic [31:0] rdata_ff;
  logic aux1_ff;
  logic aux2_ff;
  logic disp_ff;
  logic irq_ff;
  logic clr1;
  logic clr2;
  osca_clrsel_t sel;
  logic [31:0] nxt_rdata;
  wire wr_ctrl;
  wire wr_thr1;
  wire wr_thr2;
  wire wr_clrsel;
  wire wr_irq_en;
  wire wr_irq_clr;
  wire wr_route;
  wire [1:0] rise;
  wire [1:0] irq_clr;
  wire [1:0] nxt_sts;
  wire [1:0] alarms;

  // Settings above the monitor range are pulled back to its top
  function automatic osca_count_t clamp_thr(input logic [13:0] d);
    return (d > `OSCA_CNT_MAX) ? `OSCA_CNT_MAX : d;
  endfunction : clamp_thr

  // Write decode
  assign wr_ctrl = wr_i && (addr_i == `OSCA_ADDR_CTRL);
  assign wr_thr1 = wr_i && (addr_i == `OSCA_ADDR_THR1);
  assign wr_thr2 = wr_i && (addr_i == `OSCA_ADDR_THR2);
  assign wr_clrsel = wr_i && (addr_i == `OSCA_ADDR_CLRSEL);
  assign wr_irq_en = wr_i && (addr_i == `OSCA_ADDR_IRQ_EN);
  assign wr_irq_clr = wr_i && (addr_i == `OSCA_ADDR_IRQ_CLR);
  assign wr_route = wr_i && (addr_i == `OSCA_ADDR_ROUTE);

  // Counter channel wiring
  assign c1.out_lvl = out1_i;
  assign c1.linear = ctrl_ff[`OSCA_CTRL_LIN1];
  assign c1.clear = clr1;
  assign c1.thresh = thr1_ff;
  assign c2.out_lvl = out2_i;
  assign c2.linear = ctrl_ff[`OSCA_CTRL_LIN2];
  assign c2.clear = clr2;
  assign c2.thresh = thr2_ff;

  osca_counter u_cnt1 (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .port_c(c1.cnt)
  );
  osca_counter u_cnt2 (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .port_c(c2.cnt)
  );
  osca_clear_seq u_clr (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wr_i(wr_clrsel),
    .code_i(wdata_i[1:0]),
    .clr1_o(clr1),
    .clr2_o(clr2),
    .sel_o(sel)
  );

  // Alarm rising edges are the interrupt events; set beats clear
  assign alarms = {c2.alarm, c1.alarm};
  assign rise = alarms & ~alarm_d_ff;
  assign irq_clr = wr_irq_clr ? wdata_i[1:0] : 2'h0;
  assign nxt_sts = (sts_ff & ~irq_clr) | rise;

  // Configuration registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff <= 2'h0;
      thr1_ff <= `OSCA_THR_RST;
      thr2_ff <= `OSCA_THR_RST;
      route_ff <= 4'h0;
      irq_en_ff <= 2'h0;
    end else if (ce_i) begin
      if (wr_ctrl) ctrl_ff <= wdata_i[1:0];
      // Thresholds above 9999 are clamped to the range
      if (wr_thr1) thr1_ff <= clamp_thr(wdata_i[13:0]);
      if (wr_thr2) thr2_ff <= clamp_thr(wdata_i[13:0]);
      if (wr_route) route_ff <= wdata_i[3:0];
      if (wr_irq_en) irq_en_ff <= wdata_i[1:0];
    end
  end

  // Status, routing and interrupt outputs, all registered
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sts_ff <= 2'h0;
      alarm_d_ff <= 2'h0;
      aux1_ff <= 1'b0;
      aux2_ff <= 1'b0;
      disp_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (ce_i) begin
      sts_ff <= nxt_sts;
      alarm_d_ff <= alarms;
      aux1_ff <= (route_ff[0] & c1.alarm) | (route_ff[1] & c2.alarm);
      aux2_ff <= (route_ff[2] & c1.alarm) | (route_ff[3] & c2.alarm);
      disp_ff <= c1.alarm | c2.alarm;
      irq_ff <= |(nxt_sts & irq_en_ff);
    end
  end

  // Read mux; hidden monitors read as zero, unmapped reads as zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (addr_i == `OSCA_ADDR_CTRL) begin
      nxt_rdata = {30'h0, ctrl_ff};
    end else if (addr_i == `OSCA_ADDR_THR1) begin
      nxt_rdata = {18'h0, thr1_ff};
    end else if (addr_i == `OSCA_ADDR_THR2) begin
      nxt_rdata = {18'h0, thr2_ff};
    end else if (addr_i == `OSCA_ADDR_MON1) begin
      nxt_rdata = c1.visible ? {18'h0, c1.count} : 32'h0;
    end else if (addr_i == `OSCA_ADDR_MON2) begin
      nxt_rdata = c2.visible ? {18'h0, c2.count} : 32'h0;
    end else if (addr_i == `OSCA_ADDR_CLRSEL) begin
      nxt_rdata = {30'h0, sel};
    end else if (addr_i == `OSCA_ADDR_STATUS) begin
      nxt_rdata = {28'h0, alarms, sts_ff};
    end else if (addr_i == `OSCA_ADDR_IRQ_EN) begin
      nxt_rdata = {30'h0, irq_en_ff};
    end else if (addr_i == `OSCA_ADDR_ROUTE) begin
      nxt_rdata = {28'h0, route_ff};
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      rdata_ff <= rd_i ? nxt_rdata : 32'h0000_0000;
    end
  end

  assign rdata_o = rdata_ff;
  assign aux1_o = aux1_ff;
  assign aux2_o = aux2_ff;
  assign disp_alarm_o = disp_ff;
  assign irq_o = irq_ff;
endmodule : osca_top

//--- rtl/osca_map.svh
`ifndef OSCA_MAP_SVH
`define OSCA_MAP_SVH
// Register word addresses
`define OSCA_ADDR_CTRL      4'h0
`define OSCA_ADDR_THR1      4'h1
`define OSCA_ADDR_THR2      4'h2
`define OSCA_ADDR_MON1      4'h3
`define OSCA_ADDR_MON2      4'h4
`define OSCA_ADDR_CLRSEL    4'h5
`define OSCA_ADDR_STATUS    4'h6
`define OSCA_ADDR_IRQ_EN    4'h7
`define OSCA_ADDR_IRQ_CLR   4'h8
`define OSCA_ADDR_ROUTE     4'h9
// Counting figures
`define OSCA_CNT_MAX        14'h270f
`define OSCA_PRE_LAST       7'h63
`define OSCA_THR_RST        14'h0000
// Clear selector codes
`define OSCA_CLR_NONE       2'h0
`define OSCA_CLR_OUT1       2'h1
`define OSCA_CLR_OUT2       2'h2
// Control register fields
`define OSCA_CTRL_LIN1      0
`define OSCA_CTRL_LIN2      1
`endif

//--- rtl/osca_pkg.sv
package osca_pkg;
  typedef logic [13:0] osca_count_t;
  typedef logic [1:0] osca_clrsel_t;
  typedef logic [3:0] osca_addr_t;
  typedef enum logic [2:0] {
    OSCA_IDLE  = 3'b001,
    OSCA_CLEAR = 3'b010,
    OSCA_DONE  = 3'b100
  } osca_clr_state_t;
endpackage : osca_pkg

//--- rtl/osca_cnt_if.sv
`timescale 1ns/1ns
interface osca_cnt_if;
  import osca_pkg::*;
  logic out_lvl;
  logic linear;
  logic clear;
  osca_count_t thresh;
  osca_count_t count;
  logic alarm;
  logic visible;
  modport ctl (output out_lvl, output linear, output clear, output thresh, input count, input alarm, input visible);
  modport cnt (input out_lvl, input linear, input clear, input thresh, output count, output alarm, output visible);
endinterface : osca_cnt_if

//--- rtl/osca_counter.sv
`timescale 1ns/1ns
`include "osca_map.svh"
module osca_counter (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  osca_cnt_if.cnt port_c
);
  import osca_pkg::*;
  logic prev_ff;
  logic [6:0] pre_ff;
  osca_count_t cnt_ff;
  logic alarm_ff;
  logic [6:0] nxt_pre;
  osca_count_t nxt_cnt;
  wire edge_seen;
  wire roll;
  // Only switching outputs are counted; linear outputs are ignored
  assign edge_seen = (port_c.out_lvl != prev_ff) && !port_c.linear;
  assign roll = edge_seen && (pre_ff == `OSCA_PRE_LAST);
  // Prescaler and saturating visible count
  assign nxt_pre = port_c.clear ? 7'h00 : roll ? 7'h00 : edge_seen ? pre_ff + 7'h01 : pre_ff;
  assign nxt_cnt = port_c.clear ? `OSCA_THR_RST :
                   (roll && cnt_ff != `OSCA_CNT_MAX) ? cnt_ff + 14'h0001 : cnt_ff;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_ff <= 1'b0;
      pre_ff <= 7'h00;
      cnt_ff <= `OSCA_THR_RST;
      alarm_ff <= 1'b0;
    end else if (ce_i) begin
      prev_ff <= port_c.out_lvl;
      pre_ff <= nxt_pre;
      cnt_ff <= nxt_cnt;
      // Zero threshold disables; clear drops the alarm
      alarm_ff <= !port_c.clear && (port_c.thresh != `OSCA_THR_RST) && (nxt_cnt > port_c.thresh);
    end
  end
  assign port_c.count = cnt_ff;
  assign port_c.alarm = alarm_ff;
  assign port_c.visible = (port_c.thresh != `OSCA_THR_RST) && !port_c.linear;
endmodule : osca_counter

//--- rtl/osca_clear_seq.sv
`timescale 1ns/1ns
`include "osca_map.svh"
module osca_clear_seq (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire osca_pkg::osca_clrsel_t code_i,
  output logic clr1_o,
  output logic clr2_o,
  output osca_pkg::osca_clrsel_t sel_o
);
  import osca_pkg::*;
  osca_clr_state_t st_ff;
  osca_clr_state_t nxt_st;
  osca_clrsel_t sel_ff;
  wire valid_code;
  // Codes above 2 are not accepted
  assign valid_code = (code_i == `OSCA_CLR_OUT1) || (code_i == `OSCA_CLR_OUT2);
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      OSCA_IDLE: if (wr_i && valid_code) nxt_st = OSCA_CLEAR;
      OSCA_CLEAR: nxt_st = OSCA_DONE;
      OSCA_DONE: nxt_st = OSCA_IDLE;
      default: nxt_st = OSCA_IDLE;
    endcase
  end
  // Selector holds the code while the clear runs, then returns to zero
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= OSCA_IDLE;
      sel_ff <= `OSCA_CLR_NONE;
    end else if (ce_i) begin
      st_ff <= nxt_st;
      if (st_ff == OSCA_IDLE && wr_i && valid_code) begin
        sel_ff <= code_i;
      end else if (st_ff == OSCA_DONE) begin
        sel_ff <= `OSCA_CLR_NONE;
      end
    end
  end
  assign clr1_o = (st_ff == OSCA_CLEAR) && (sel_ff == `OSCA_CLR_OUT1);
  assign clr2_o = (st_ff == OSCA_CLEAR) && (sel_ff == `OSCA_CLR_OUT2);
  assign sel_o = sel_ff;
endmodule : osca_clear_seq

//--- bench/osca_chk_properties.sv
`timescale 1ns/1ns
`include "osca_map.svh"
module osca_chk (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire osca_pkg::osca_addr_t addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic aux1_o,
  input wire logic aux2_o,
  input wire logic disp_alarm_o,
  input wire logic irq_o
);
  import osca_pkg::*;
  // A frozen block holds every output, so checks pause while ce_i is low
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i || !ce_i);
  chk_read_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero after idle cycle");
  chk_thr_readback: assert property (
    wr_i && addr_i == `OSCA_ADDR_THR2 && wdata_i[13:0] <= `OSCA_CNT_MAX ##1 rd_i && addr_i == `OSCA_ADDR_THR2
    |=> rdata_o == {18'h0, $past(wdata_i[13:0], 2)}) else $error("threshold read back differs");
  chk_thr_clamp: assert property (
    wr_i && addr_i == `OSCA_ADDR_THR2 && wdata_i[13:0] > `OSCA_CNT_MAX ##1 rd_i && addr_i == `OSCA_ADDR_THR2
    |=> rdata_o == 32'(`OSCA_CNT_MAX)) else $error("oversize threshold not clamped");
  chk_zero_hides: assert property (
    wr_i && addr_i == `OSCA_ADDR_THR1 && wdata_i == 32'h0 ##1 rd_i && addr_i == `OSCA_ADDR_MON1
    |=> rdata_o == 32'h0) else $error("monitor shown with zero threshold");
  chk_sel_return: assert property (
    wr_i && addr_i == `OSCA_ADDR_CLRSEL && wdata_i[1:0] inside {2'h1, 2'h2} ##3 rd_i && addr_i == `OSCA_ADDR_CLRSEL
    |=> rdata_o == 32'h0) else $error("selector not back to idle");
  chk_aux_disp: assert property ((aux1_o || aux2_o) |-> disp_alarm_o)
    else $error("routed alarm without display alarm");
  chk_irq_off: assert property (
    wr_i && addr_i == `OSCA_ADDR_IRQ_EN && wdata_i[1:0] == 2'h0 ##1 !(wr_i && addr_i == `OSCA_ADDR_IRQ_EN)
    |=> !irq_o) else $error("interrupt high with all enables off");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !disp_alarm_o && rdata_o == 32'h0)
    else $error("outputs not quiet after reset");
endmodule : osca_chk

//--- bench/osca_out_drv.sv
`timescale 1ns/1ns
module osca_out_drv (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [15:0] n_i,
  input wire logic [1:0] gap_i,
  output logic out_o,
  output logic busy_o
);
  logic [15:0] left_ff;
  logic [1:0] wait_ff;
  // Relay-like level, one change per switching, gap_i idle cycles between
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      left_ff <= 16'h0;
      wait_ff <= 2'h0;
      out_o <= 1'b0;
    end else if (go_i) begin
      left_ff <= n_i;
      wait_ff <= gap_i;
    end else if (left_ff != 16'h0) begin
      if (wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
      end else begin
        out_o <= ~out_o;
        left_ff <= left_ff - 16'h1;
        wait_ff <= gap_i;
      end
    end
  end
  assign busy_o = (left_ff != 16'h0) || go_i;
endmodule : osca_out_drv

//--- bench/testbench.sv
`timescale 1ns/1ns
`include "osca_map.svh"
module testbench;
  import osca_pkg::*;
  logic mclk_i;
  logic rst_i;
  logic ce;
  logic wr_i;
  logic rd_i;
  osca_addr_t addr_i;
  logic [31:0] wdata_i;
  logic [31:0] rdata_o;
  logic [3:0] o;
  logic [1:0] go;
  logic [1:0] lvl;
  logic [1:0] busy;
  logic [15:0] num;
  logic [1:0] gap;
  logic [31:0] v;
  int n_mismatch;
  int n_checks;
  int cnt [2];
  int t;
  osca_top i_osca_top (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .out1_i(lvl[0]), .out2_i(lvl[1]),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .aux1_o(o[0]),
    .aux2_o(o[1]), .disp_alarm_o(o[2]), .irq_o(o[3]));
  osca_out_drv i_drv [1:0] (.mclk_i(mclk_i), .rst_i(rst_i), .go_i(go), .n_i(num), .gap_i(gap), .out_o(lvl),
    .busy_o(busy));
  // 250 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  function automatic logic [31:0] mon(input int c);
    return (c / 100 > 9999) ? 32'(`OSCA_CNT_MAX) : 32'(c / 100);
  endfunction : mon
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  // One bus cycle; strobes stay up until the next call sets them
  task automatic bus(input logic w, input logic r, input osca_addr_t a, input logic [31:0] d);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
  endtask : bus
  task automatic rd(input osca_addr_t a);
    bus(1'b0, 1'b1, a, 32'h0);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    v = rdata_o;
    @(posedge mclk_i);
  endtask : rd
  // Bounded wait for the partner to finish its switchings
  task automatic sw(input int k, input int n, input logic [1:0] g, input logic c);
    int i;
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    num <= 16'(n);
    gap <= g;
    go[k] <= 1'b1;
    @(posedge mclk_i);
    go[k] <= 1'b0;
    for (i = 0; i < 4000 && busy[k] !== 1'b0; i++) begin
      @(posedge mclk_i);
    end
    if (i == 4000) begin
      n_mismatch++;
      stop_test();
    end
    repeat (3) @(posedge mclk_i);
    if (c) begin
      cnt[k] += n;
    end
  endtask : sw
  initial begin
    rst_i = 1'b1;
    ce = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 32'h0;
    go = 2'h0;
    num = 16'h0;
    gap = 2'h0;
    n_mismatch = 0;
    n_checks = 0;
    cnt = '{0, 0};
    v = $urandom(73413);
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    for (int a = 0; a < 16; a++) begin
      rd(4'(a));
      chk(v, 32'h0, "reset");
    end
    t = $urandom_range(9999, 1);
    bus(1'b1, 1'b0, `OSCA_ADDR_THR2, 32'(t));
    rd(`OSCA_ADDR_THR2);
    chk(v, 32'(t), "thr2");
    // Only bits 13:0 hold the setting, so the oversize value must live there
    bus(1'b1, 1'b0, `OSCA_ADDR_THR2, 32'(t) | 32'h2710);
    rd(`OSCA_ADDR_THR2);
    chk(v, 32'(`OSCA_CNT_MAX), "clamp");
    bus(1'b1, 1'b0, `OSCA_ADDR_ROUTE, 32'h9);
    bus(1'b1, 1'b0, `OSCA_ADDR_IRQ_EN, 32'h3);
    // Count to the threshold, one step past it, then clear; output two slow
    for (int k = 0; k < 2; k++) begin
      t = $urandom_range(3, 1);
      bus(1'b1, 1'b0, osca_addr_t'(k + 1), 32'(t));
      sw(k, 100 * t + $urandom_range(99, 0), 2'(2 * k), 1'b1);
      rd(osca_addr_t'(k + 3));
      chk(v, mon(cnt[k]), "count");
      chk(32'(o[2]), 32'h0, "alarm at threshold");
      sw(k, 100, 2'h0, 1'b1);
      chk(32'(o), {28'h0, 2'h3, k[0], ~k[0]}, "alarm outputs");
      rd(`OSCA_ADDR_STATUS);
      chk(v, 32'h5 << k, "status");
      bus(1'b1, 1'b0, `OSCA_ADDR_IRQ_CLR, 32'h1 << k);
      repeat (2) bus(1'b0, 1'b0, 4'h0, 32'h0);
      chk(32'(o[3]), 32'h0, "irq cleared");
      for (int c = 0; c < 4; c += 3) begin
        bus(1'b1, 1'b0, `OSCA_ADDR_CLRSEL, 32'(c));
        rd(osca_addr_t'(k + 3));
        chk(v, mon(cnt[k]), "ignored code");
      end
      bus(1'b1, 1'b0, `OSCA_ADDR_CLRSEL, 32'(k + 1));
      repeat (2) bus(1'b0, 1'b0, 4'h0, 32'h0);
      rd(`OSCA_ADDR_CLRSEL);
      chk(v, 32'h0, "selector idle");
      cnt[k] = 0;
      rd(osca_addr_t'(k + 3));
      chk(v, 32'h0, "cleared");
      chk(32'(o[2]), 32'h0, "alarm dropped");
    end
    // Even toggle count while linear, so the level ends where it began
    bus(1'b1, 1'b0, `OSCA_ADDR_CTRL, 32'h1);
    rd(`OSCA_ADDR_MON1);
    chk(v, 32'h0, "linear hidden");
    sw(0, 150, 2'h1, 1'b0);
    bus(1'b1, 1'b0, `OSCA_ADDR_CTRL, 32'h0);
    sw(0, 100, 2'h0, 1'b1);
    rd(`OSCA_ADDR_MON1);
    chk(v, mon(cnt[0]), "linear uncounted");
    // A write while the clock enable is low must be lost
    bus(1'b1, 1'b0, `OSCA_ADDR_THR1, 32'h7);
    ce <= 1'b0;
    bus(1'b1, 1'b0, `OSCA_ADDR_THR1, 32'h5);
    ce <= 1'b1;
    rd(`OSCA_ADDR_THR1);
    chk(v, 32'h7, "frozen write");
    bus(1'b1, 1'b0, `OSCA_ADDR_THR1, 32'h0);
    rd(`OSCA_ADDR_MON1);
    chk(v, 32'h0, "zero threshold");
    bus(1'b1, 1'b0, `OSCA_ADDR_IRQ_EN, 32'h0);
    repeat (2) bus(1'b0, 1'b0, 4'h0, 32'h0);
    stop_test();
  end
endmodule : testbench
bind osca_top osca_chk i_osca_chk (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .aux1_o(aux1_o), .aux2_o(aux2_o),
  .disp_alarm_o(disp_alarm_o), .irq_o(irq_o));
